// >>> src/jla_pkg.sv
/*
  Package for the link parameter and alignment block: field widths, fixed
  link parameter encodings, subclass codes and timing counts.
  Assumes a single 250 MHz device clock domain.
*/
`default_nettype none
package jla_pkg;
  localparam int CLK_MHZ = 250;
  // Fixed link parameters, already minus-one where the field is a count
  localparam logic [4:0] LANES_M1_ONE = 5'h01;
  localparam logic [4:0] LANES_M1_TWO = 5'h03;
  localparam logic [4:0] SPF_M1_ONE = 5'h00;
  localparam logic [4:0] SPF_M1_TWO = 5'h01;
  localparam logic [7:0] OCT_M1 = 8'h01;
  localparam logic [7:0] CONV_M1 = 8'h01;
  localparam logic [4:0] RES_M1 = 5'h0D;
  localparam logic [4:0] BPS_M1 = 5'h0F;
  localparam logic [1:0] CTRL_BITS = 2'h1;
  localparam logic [2:0] VERSION = 3'h1;
  localparam logic HIGH_DENS = 1'b0;
  localparam logic [4:0] CTRL_PER_FRAME = 5'h00;
  localparam logic [3:0] ADJ_CNT = 4'h0;
  localparam logic ADJ_DIR = 1'b0;
  localparam logic PH_ADJ = 1'b0;
  // Subclass codes
  localparam logic [2:0] SUBCL_0 = 3'h0;
  localparam logic [2:0] SUBCL_1 = 3'h1;
  localparam logic [2:0] SUBCL_2 = 3'h2;
  // Frame clock period in device clocks (one sample per frame per lane)
  localparam logic [1:0] FRAME_DIV = 2'h2;
  // SYNC~ assertion is taken on this frame clock edge
  localparam logic [2:0] SYNC_DET_EDGE = 3'h5;
  localparam logic [7:0] ALERT_TMO_RST = 8'h04;
endpackage
`default_nettype wire

// >>> src/jla_edge_sync.sv
/*
  Pin input synchroniser with rising and falling edge pulses.
  Assumes the input is asynchronous to clk_i.
*/
`default_nettype none
module jla_edge_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);
  logic s1_ff, s2_ff, s3_ff;
  // First stage read only by second stage; a change counts when 2 and 3 agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
      s3_ff <= 1'b1;
    end else begin
      s1_ff <= pin_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_o <= 1'b1;
    end else if (s2_ff == s3_ff) begin
      level_o <= s3_ff;
    end
  end
  assign rise_o = (s2_ff == s3_ff) && s3_ff && !level_o;
  assign fall_o = (s2_ff == s3_ff) && !s3_ff && level_o;
endmodule
`default_nettype wire

// >>> src/jla_align.sv
/*
  Link parameter set and deterministic-latency alignment for a dual 14-bit
  converter transmitter. Builds the configuration fields and checksum,
  runs the local frame and multiframe clocks, and realigns them from
  SYSREF (subclass 1, optional alert mode) or SYNC~ release (subclass 2).
  Assumes SYSREF and SYNC~ arrive asynchronously and configuration inputs
  are static-ish levels from the device clock domain.
*/
`default_nettype none
module jla_align
  import jla_pkg::*;
#(
  parameter int K_W = 5
) (
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  input wire logic SYSREF_I,
  input wire logic SYNC_N_I,
  input wire logic TWO_LANE_I,
  input wire logic [7:0] DEV_ID_I,
  input wire logic [3:0] BANK_ID_I,
  input wire logic [K_W-1:0] K_M1_I,
  input wire logic SCRAMBLE_I,
  input wire logic [2:0] SUBCLASS_I,
  input wire logic ALERT_EN_I,
  input wire logic [7:0] ALERT_TMO_I,
  output logic [4:0] LANES_M1_O,
  output logic [4:0] SPF_M1_O,
  output logic [7:0] CHECKSUM_O,
  output logic [7:0] DEV_ID_O,
  output logic [3:0] BANK_ID_O,
  output logic [K_W-1:0] K_M1_O,
  output logic SCRAMBLE_O,
  output logic [2:0] SUBCLASS_O,
  output logic FRAME_TICK_O,
  output logic MFRAME_TICK_O,
  output logic SEND_K28_5_O,
  output logic ALIGN_PULSE_O,
  output logic ALERT_ARMED_O
);
  import jla_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Synchronised pins
  logic sref_rise, sync_lvl, sync_rise, sync_fall;
  jla_edge_sync u_sref (
    .clk_i(MCLK_I),
    .rst_i(SYS_RST_I),
    .pin_i(SYSREF_I),
    .level_o(),
    .rise_o(sref_rise),
    .fall_o()
  );
  jla_edge_sync u_sync (
    .clk_i(MCLK_I),
    .rst_i(SYS_RST_I),
    .pin_i(SYNC_N_I),
    .level_o(sync_lvl),
    .rise_o(sync_rise),
    .fall_o(sync_fall)
  );

  //////////////////////////////////////////////////////////////////////////
  // Configuration fields and checksum
  logic [4:0] lanes_m1, spf_m1;
  logic [4:0] lane_id;
  logic [7:0] sum;
  assign lanes_m1 = TWO_LANE_I ? LANES_M1_TWO : LANES_M1_ONE;
  assign spf_m1 = TWO_LANE_I ? SPF_M1_TWO : SPF_M1_ONE;
  assign lane_id = 5'h00;
  always_comb begin
    // Lane ID field of the first lane; each lane adds its own ID after
    sum = DEV_ID_I + 8'(BANK_ID_I) + 8'(ADJ_CNT) + 8'(ADJ_DIR)
      + 8'(PH_ADJ) + 8'(lane_id) + 8'(SCRAMBLE_I) + 8'(lanes_m1)
      + OCT_M1 + 8'(K_M1_I) + CONV_M1 + 8'(CTRL_BITS) + 8'(RES_M1)
      + 8'(SUBCLASS_I) + 8'(BPS_M1) + 8'(VERSION) + 8'(spf_m1)
      + 8'(HIGH_DENS) + 8'(CTRL_PER_FRAME);
  end
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      LANES_M1_O <= LANES_M1_ONE;
      SPF_M1_O <= SPF_M1_ONE;
      CHECKSUM_O <= 8'h00;
      DEV_ID_O <= 8'h00;
      BANK_ID_O <= 4'h0;
      K_M1_O <= '0;
      SCRAMBLE_O <= 1'b0;
      SUBCLASS_O <= 3'h0;
    end else begin
      LANES_M1_O <= lanes_m1;
      SPF_M1_O <= spf_m1;
      CHECKSUM_O <= sum;
      DEV_ID_O <= DEV_ID_I;
      BANK_ID_O <= BANK_ID_I;
      K_M1_O <= K_M1_I;
      SCRAMBLE_O <= SCRAMBLE_I;
      SUBCLASS_O <= SUBCLASS_I;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Alignment source and subclass 1 alert arming
  typedef enum logic [1:0] {
    AL_IDLE = 2'b01,
    AL_ARMED = 2'b10
  } jla_alert_e;
  jla_alert_e alert_ff;
  logic [7:0] tmo_ff;
  logic align;
  logic mf_tick;
  logic s1_hit;
  assign s1_hit = (SUBCLASS_I == SUBCL_1) && sref_rise;
  always_comb begin
    align = 1'b0;
    unique case (SUBCLASS_I)
      SUBCL_1: align = s1_hit && (!ALERT_EN_I || alert_ff == AL_ARMED);
      SUBCL_2: align = sync_rise;
      default: align = 1'b0;
    endcase
  end
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      alert_ff <= AL_IDLE;
      tmo_ff <= ALERT_TMO_RST;
    end else if (!ALERT_EN_I || SUBCLASS_I != SUBCL_1) begin
      alert_ff <= AL_IDLE;
    end else begin
      unique case (alert_ff)
        AL_IDLE: if (s1_hit) begin
          alert_ff <= AL_ARMED;
          tmo_ff <= ALERT_TMO_I;
        end
        AL_ARMED: if (s1_hit) begin
          alert_ff <= AL_IDLE;
        end else if (mf_tick) begin
          // Zero means disarm on the first multiframe edge after arming
          if (tmo_ff <= 8'h01) begin
            alert_ff <= AL_IDLE;
          end
          tmo_ff <= tmo_ff - 8'h01;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Local frame and multiframe clocks
  logic [1:0] fdiv_ff;
  logic [K_W-1:0] fcnt_ff;
  logic f_tick;
  assign f_tick = (fdiv_ff == FRAME_DIV - 2'h1);
  assign mf_tick = f_tick && (fcnt_ff == K_M1_I);
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I || align) begin
      // Reset at the detection edge itself, not a frame later
      fdiv_ff <= 2'h0;
      fcnt_ff <= '0;
    end else if (f_tick) begin
      fdiv_ff <= 2'h0;
      fcnt_ff <= mf_tick ? '0 : fcnt_ff + 1'b1;
    end else begin
      fdiv_ff <= fdiv_ff + 2'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // SYNC~ request detection and K28.5 broadcast
  logic [2:0] lo_cnt_ff;
  logic req_ff;
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      lo_cnt_ff <= 3'h0;
      req_ff <= 1'b0;
    end else if (sync_lvl) begin
      lo_cnt_ff <= 3'h0;
    end else if (f_tick && lo_cnt_ff != SYNC_DET_EDGE) begin
      lo_cnt_ff <= lo_cnt_ff + 3'h1;
      if (lo_cnt_ff == SYNC_DET_EDGE - 3'h1) begin
        req_ff <= 1'b1;
      end
    end else if (sync_fall) begin
      lo_cnt_ff <= 3'h0;
    end
    if (!SYS_RST_I && sync_rise) begin
      req_ff <= 1'b0;
    end
  end
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      SEND_K28_5_O <= 1'b0;
      FRAME_TICK_O <= 1'b0;
      MFRAME_TICK_O <= 1'b0;
      ALIGN_PULSE_O <= 1'b0;
      ALERT_ARMED_O <= 1'b0;
    end else begin
      // K28.5 starts and stops only on a frame boundary
      if (f_tick) begin
        SEND_K28_5_O <= req_ff;
      end
      FRAME_TICK_O <= f_tick && !align;
      MFRAME_TICK_O <= mf_tick && !align;
      ALIGN_PULSE_O <= align;
      ALERT_ARMED_O <= (alert_ff == AL_ARMED);
    end
  end
endmodule
`default_nettype wire

// >>> test/jla_rx_model.sv
/* Receiver model: drives the active-low sync request toward the block.
   Assumes the bench raises req_i to ask for synchronization. */
`default_nettype none
module jla_rx_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  output logic sync_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released only on a clock edge, as a receiver at its multiframe edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_n_o <= 1'b1;
    end else begin
      sync_n_o <= ~req_i;
    end
  end
endmodule
`default_nettype wire

// >>> test/jla_align_asserts.sv
/* Port assertions for the alignment block.
   Assumes one clock domain; attached by the bind at the foot. */
`default_nettype none
module jla_align_asserts
  import jla_pkg::*;
#(parameter int K_W = 5) (
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  input wire logic SYSREF_I,
  input wire logic SYNC_N_I,
  input wire logic TWO_LANE_I,
  input wire logic [7:0] DEV_ID_I,
  input wire logic [2:0] SUBCLASS_I,
  input wire logic ALERT_EN_I,
  input wire logic [4:0] LANES_M1_O,
  input wire logic [4:0] SPF_M1_O,
  input wire logic [7:0] CHECKSUM_O,
  input wire logic [7:0] DEV_ID_O,
  input wire logic [3:0] BANK_ID_O,
  input wire logic [K_W-1:0] K_M1_O,
  input wire logic SCRAMBLE_O,
  input wire logic [2:0] SUBCLASS_O,
  input wire logic MFRAME_TICK_O,
  input wire logic SEND_K28_5_O,
  input wire logic ALIGN_PULSE_O,
  input wire logic ALERT_ARMED_O
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sum_w;
  // Fixed fields of the package add up to 8'h20
  assign sum_w = DEV_ID_O + BANK_ID_O + SCRAMBLE_O + LANES_M1_O + K_M1_O
    + SUBCLASS_O + SPF_M1_O + 8'h20;
  // Cycles since the last alignment, until the first multiframe tick after it
  logic [7:0] al_age;
  logic al_mf_open;
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      al_age <= 8'h00;
      al_mf_open <= 1'b0;
    end else if (ALIGN_PULSE_O) begin
      al_age <= 8'h01;
      al_mf_open <= 1'b1;
    end else begin
      al_age <= al_age + 8'h01;
      if (MFRAME_TICK_O) begin
        al_mf_open <= 1'b0;
      end
    end
  end
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (SYS_RST_I);
  ////////////////////////////////////////////////////////////////////////
  a_lane_count: assert property (!$past(SYS_RST_I) |->
    LANES_M1_O == ($past(TWO_LANE_I) ? 5'h03 : 5'h01) &&
    SPF_M1_O == ($past(TWO_LANE_I) ? 5'h01 : 5'h00))
    else $error("lane or sample count wrong");
  a_field_copy: assert property (!$past(SYS_RST_I) |->
    DEV_ID_O == $past(DEV_ID_I) && SUBCLASS_O == $past(SUBCLASS_I))
    else $error("programmable field not reflected");
  a_checksum_sum: assert property (!$past(SYS_RST_I) |->
    CHECKSUM_O == sum_w) else $error("checksum wrong");
  a_sub0_quiet: assert property ((SUBCLASS_I == 3'h0)[*6] |->
    !ALIGN_PULSE_O) else $error("alignment in subclass 0");
  a_sysref_align: assert property (SUBCLASS_I == 3'h1 && !ALERT_EN_I &&
    $rose(SYSREF_I) |-> ##[1:6] ALIGN_PULSE_O)
    else $error("no alignment on reference edge");
  a_alert_arms: assert property (SUBCLASS_I == 3'h1 && ALERT_EN_I &&
    !ALERT_ARMED_O && $rose(SYSREF_I) |-> (!ALIGN_PULSE_O)[*6])
    else $error("first reference pulse aligned");
  a_sync_align: assert property (SUBCLASS_I == 3'h2 &&
    $rose(SYNC_N_I) |-> ##[1:6] ALIGN_PULSE_O)
    else $error("no alignment on sync release");
  a_k28_after_sync: assert property ($rose(SEND_K28_5_O) |->
    !$past(SYNC_N_I, 8)) else $error("early control symbols");
  a_align_single: assert property (ALIGN_PULSE_O |=> !ALIGN_PULSE_O)
    else $error("alignment pulse too long");
  a_mf_after_align: assert property (al_mf_open && MFRAME_TICK_O |->
    al_age == 8'(FRAME_DIV) * (8'(K_M1_O) + 8'h01))
    else $error("multiframe not restarted at alignment");
  c_align: cover property (ALIGN_PULSE_O);
  c_armed: cover property ($rose(ALERT_ARMED_O));
  c_k28: cover property ($rose(SEND_K28_5_O));
endmodule
bind jla_align jla_align_asserts #(.K_W(K_W)) u_chk (.*);
`default_nettype wire

// >>> test/tb_jla_align.sv
/* Self-checking bench for the alignment block.
   Assumes the receiver model owns the sync pin. */
`default_nettype none
module tb_jla_align;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, sref = 0, req = 0, two = 0, scr = 0, aen = 0;
  logic sync_n, fr, mf, k28, alp, arm;
  logic [7:0] did = 8'h00, tmo = 8'h04, cks, dido;
  logic [3:0] bid = 4'h0, bido;
  logic [4:0] km1 = 5'h03, km1o, ln, spf;
  logic [2:0] sub = 3'h0, subo;
  logic scro;
  int mismatches = 0, compares = 0, n_al = 0, n_fr = 0, n_mf = 0;
  always #2 clk = ~clk;
  always @(posedge clk) begin
    if (alp === 1'b1) n_al++;
    if (fr === 1'b1) n_fr++;
    if (mf === 1'b1) n_mf++;
  end
  jla_rx_model u_rx (.clk_i(clk), .rst_i(rst), .req_i(req),
    .sync_n_o(sync_n));
  jla_align dut (.MCLK_I(clk), .SYS_RST_I(rst), .SYSREF_I(sref),
    .SYNC_N_I(sync_n), .TWO_LANE_I(two), .DEV_ID_I(did), .BANK_ID_I(bid),
    .K_M1_I(km1), .SCRAMBLE_I(scr), .SUBCLASS_I(sub), .ALERT_EN_I(aen),
    .ALERT_TMO_I(tmo), .LANES_M1_O(ln), .SPF_M1_O(spf), .CHECKSUM_O(cks),
    .DEV_ID_O(dido), .BANK_ID_O(bido), .K_M1_O(km1o), .SCRAMBLE_O(scro),
    .SUBCLASS_O(subo), .FRAME_TICK_O(fr), .MFRAME_TICK_O(mf),
    .SEND_K28_5_O(k28), .ALIGN_PULSE_O(alp), .ALERT_ARMED_O(arm));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse();
    sref = 1;
    cyc(4);
    sref = 0;
    cyc(12);
  endtask
  task automatic t_params();
    logic [7:0] es;
    for (int i = 0; i < 2; i++) begin
      two = i[0];
      did = 8'hA5 + 8'(i);
      bid = 4'hC;
      scr = i[0];
      sub = 3'h2;
      cyc(3);
      chk("lanes", i ? 8'h03 : 8'h01, {3'h0, ln});
      chk("spf", 8'(i), {3'h0, spf});
      chk("did", did, dido);
      chk("bid", 8'h0C, {4'h0, bido});
      chk("scr", 8'(i), {7'h0, scro});
      chk("sub", 8'h02, {5'h0, subo});
      chk("k", {3'h0, km1}, {3'h0, km1o});
      es = did + 8'h0C + 8'(i) + (i ? 8'h04 : 8'h01) + 8'h03 + 8'h22;
      chk("sum", es, cks);
    end
    $display("params done");
  endtask
  task automatic t_sub0();
    int n, f, m, ef;
    sub = 3'h0;
    cyc(8);
    n = n_al;
    pulse();
    chk("sub0 align", 8'(n), 8'(n_al));
    f = n_fr;
    m = n_mf;
    ef = 64 / jla_pkg::FRAME_DIV;
    cyc(64);
    chk("frames", 8'(ef), 8'(n_fr - f));
    chk("mframes", 8'(ef / (km1 + 1)), 8'(n_mf - m));
    $display("subclass 0 done");
  endtask
  task automatic t_sub1();
    int n;
    sub = 3'h1;
    cyc(8);
    n = n_al;
    pulse();
    chk("sub1 align", 8'(n + 1), 8'(n_al));
    aen = 1;
    cyc(40);
    pulse();
    chk("armed", 8'h01, {7'h0, arm});
    chk("first pulse", 8'(n + 1), 8'(n_al));
    pulse();
    chk("second pulse", 8'(n + 2), 8'(n_al));
    pulse();
    chk("rearmed", 8'h01, {7'h0, arm});
    chk("third pulse", 8'(n + 2), 8'(n_al));
    cyc(80);
    chk("disarm", 8'h00, {7'h0, arm});
    pulse();
    chk("after disarm", 8'(n + 2), 8'(n_al));
    aen = 0;
    $display("subclass 1 done");
  endtask
  task automatic t_sub2();
    int n;
    sub = 3'h2;
    req = 1;
    cyc(40);
    chk("k28 on", 8'h01, {7'h0, k28});
    n = n_al;
    req = 0;
    cyc(10);
    chk("sub2 align", 8'(n + 1), 8'(n_al));
    cyc(20);
    chk("k28 off", 8'h00, {7'h0, k28});
    $display("subclass 2 done");
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #20000;
    mismatches++;
    summarize();
  end
  initial begin
    cyc(20);
    rst = 0;
    cyc(2);
    t_params();
    t_sub0();
    t_sub1();
    t_sub2();
    summarize();
  end
endmodule
`default_nettype wire
